// ---- hdl/rdcfg_pin_sync.sv ----
// two-flop synchroniser for all asynchronous two-level pins
// assumes pins are quasi-static relative to the 10 MHz clock
`timescale 1ns/100ps
module rdcfg_pin_sync
	import rdcfg_pkg::*;
#(
	parameter int unsigned W = 8
) (
	input  wire logic         i_clock,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_pins,
	rdcfg_sync_if.src         sync
);
	logic [W-1:0] meta;
	logic [W-1:0] held;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_held;

	always_comb begin
		next_meta = i_pins;
		next_held = meta;
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			meta <= {W{1'b0}};
			held <= {W{1'b0}};
		end else begin
			meta <= next_meta;
			held <= next_held;
		end
	end

	// sleep defaults to 1 through held reset value would need a constant; zero is safe
	assign sync.swap               = held[0];
	assign sync.sleep_in_n         = held[1];
	assign sync.flip_scl           = held[2];
	assign sync.ctl_sda            = held[3];
	assign sync.dp_enable_in       = held[4];
	assign sync.hot_plug_detect_in = held[5];
	assign sync.lane_dir_sel       = held[7:6];
endmodule

// ---- hdl/rdcfg_pkg.sv ----
// constants, codes and types for the redriver pin and strap decode
// assumes a single 10 MHz clock and a synchronous active-high reset
//
// What this block does
// - swap input high exchanges upstream and downstream directions and equalizer settings
// - sleep input low disables receiver detect; high keeps it enabled
// - sleep low in U2/U3 turns off LOS and LFPS detect, termination on
// - sleep low while disconnected disables receiver detect and termination
// - control strap: 0 gpio, R test with serial, F gpio no snoop, 1 serial
// - control strap 0 makes shared pin the flip control, else serial clock
// - control strap 0 makes shared pin the usb enable, else serial data
// - gpio mode takes dp enable from pin, serial mode from register
// - upstream equalizer straps pick upstream gain; in serial mode also the address
// - output straps pick swing linearity range and dc gain for all channels
// - the two direction inputs pick the lane direction format
// - io level strap picks config io and serial port voltages
// - aux pair is snooped except with control strap F; sideband crossing follows plug orientation only with control strap 0, else held off
// - gpio mode, hot plug low over 2 ms disables dp lanes, aux switch closed
// - downstream equalizer straps pick downstream gain
package rdcfg_pkg;
	// ------------------------------------------------------------
	// four-level strap codes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		RDCFG_LVL_0 = 2'h0,
		RDCFG_LVL_R = 2'h1,
		RDCFG_LVL_F = 2'h2,
		RDCFG_LVL_1 = 2'h3
	} rdcfg_lvl_t;

	// link power states seen by the sleep logic
	typedef enum logic [1:0] {
		RDCFG_LINK_ACTIVE = 2'h0,
		RDCFG_LINK_U2U3   = 2'h1,
		RDCFG_LINK_DISC   = 2'h2
	} rdcfg_link_t;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS  = 100;
	localparam int unsigned HPD_LOW_TIME_MS = 2;
	localparam int unsigned HPD_LOW_CYCLES =
		(HPD_LOW_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned HPD_CNT_W      = 16;

	// ------------------------------------------------------------
	// reset values of captured straps and defaults
	// ------------------------------------------------------------
	localparam logic [1:0] STRAP_RESET  = 2'h0;
	localparam logic       SWAP_DEFAULT = 1'b0;
endpackage

// ---- hdl/rdcfg_sync_if.sv ----
// interface carrying the synchronised two-level pins between the two modules
// assumes both ends run on the one block clock
`timescale 1ns/100ps
interface rdcfg_sync_if;
	logic       swap;
	logic       sleep_in_n;
	logic       flip_scl;
	logic       ctl_sda;
	logic       dp_enable_in;
	logic       hot_plug_detect_in;
	logic [1:0] lane_dir_sel;
	modport src (output swap, sleep_in_n, flip_scl, ctl_sda, dp_enable_in,
		hot_plug_detect_in, lane_dir_sel);
	modport dst (input swap, sleep_in_n, flip_scl, ctl_sda, dp_enable_in,
		hot_plug_detect_in, lane_dir_sel);
endinterface

// ---- hdl/rdcfg_top.sv ----
// strap capture and control decode of the redriver
// assumes straps already resolved to two-bit level codes by the analog front end
`timescale 1ns/100ps
module rdcfg_top
	import rdcfg_pkg::*;
#(
	parameter int unsigned HPD_CYCLES = HPD_LOW_CYCLES
) (
	input  wire logic       I_CLOCK,
	input  wire logic       I_RST,
	input  wire logic [1:0] i_ctl_mode_strap,
	input  wire logic [1:0] i_io_level_strap,
	input  wire logic [1:0] i_up_eq_strap_lo,
	input  wire logic [1:0] i_up_eq_strap_hi,
	input  wire logic [1:0] i_down_eq_strap_lo,
	input  wire logic [1:0] i_down_eq_strap_hi,
	input  wire logic [1:0] i_out_cfg_strap_lo,
	input  wire logic [1:0] i_out_cfg_strap_hi,
	input  wire logic       i_swap,
	input  wire logic       i_sleep_in_n,
	input  wire logic       i_flip_scl,
	input  wire logic       i_usb_switch_enable_in,
	input  wire logic       i_dp_enable_in,
	input  wire logic       i_hot_plug_detect_in,
	input  wire logic       i_lane_dir_sel_lo,
	input  wire logic       i_lane_dir_sel_hi,
	input  wire logic [1:0] i_link_state,
	input  wire logic       i_reg_dp_enable,
	output logic            O_SERIAL_EN,
	output logic            O_TEST_MODE,
	output logic            O_AUX_SNOOP_EN,
	output logic            O_FLIP,
	output logic            O_USB_EN,
	output logic            O_SCL,
	output logic            O_SDA,
	output logic            O_DP_EN,
	output logic            O_DP_LANES_EN,
	output logic [3:0]      O_UP_EQ,
	output logic [3:0]      O_DOWN_EQ,
	output logic [3:0]      O_OUT_CFG,
	output logic [3:0]      O_ADDR_SEL,
	output logic [1:0]      O_LANE_DIR,
	output logic            O_SWAP,
	output logic            O_CFG_IO_1V8,
	output logic            O_SERIAL_IO_1V8,
	output logic            O_RX_DETECT_EN,
	output logic            O_RX_TERM_EN,
	output logic            O_LOS_LFPS_EN,
	output logic            O_SBU_CROSS,
	output logic            O_AUX_SBU_CLOSED
);
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	rdcfg_sync_if sync ();

	rdcfg_pin_sync #(.W(8)) rdcfg_pin_sync_i (
		.i_clock (I_CLOCK),
		.i_rst   (I_RST),
		.i_pins  ({i_lane_dir_sel_hi, i_lane_dir_sel_lo, i_hot_plug_detect_in,
			i_dp_enable_in, i_usb_switch_enable_in, i_flip_scl, i_sleep_in_n, i_swap}),
		.sync    (sync)
	);

	// ------------------------------------------------------------
	// strap capture
	// ------------------------------------------------------------
	logic [1:0]  ctl_mode;
	logic [1:0]  io_level;
	logic [3:0]  up_eq;
	logic [3:0]  down_eq;
	logic [3:0]  out_cfg;
	logic        captured;
	logic [15:0] strap_meta;
	logic [15:0] strap_sync;
	logic [1:0]  strap_vld;
	logic [1:0]  next_ctl_mode;
	logic [1:0]  next_io_level;
	logic [3:0]  next_up_eq;
	logic [3:0]  next_down_eq;
	logic [3:0]  next_out_cfg;
	logic        next_captured;
	logic [15:0] next_strap_meta;
	logic [15:0] next_strap_sync;
	logic [1:0]  next_strap_vld;

	// straps cross two flops like any pin; capture waits until the pair holds a real sample
	// later pin changes are ignored until the next reset
	always_comb begin
		next_strap_meta = {i_out_cfg_strap_hi, i_out_cfg_strap_lo, i_down_eq_strap_hi,
			i_down_eq_strap_lo, i_up_eq_strap_hi, i_up_eq_strap_lo, i_io_level_strap,
			i_ctl_mode_strap};
		next_strap_sync = strap_meta;
		next_strap_vld  = {strap_vld[0], 1'b1};
		next_ctl_mode   = ctl_mode;
		next_io_level   = io_level;
		next_up_eq      = up_eq;
		next_down_eq    = down_eq;
		next_out_cfg    = out_cfg;
		next_captured   = captured;
		if (!captured && strap_vld[1]) begin
			next_captured = 1'b1;
			next_ctl_mode = strap_sync[1:0];
			next_io_level = strap_sync[3:2];
			next_up_eq    = strap_sync[7:4];
			next_down_eq  = strap_sync[11:8];
			next_out_cfg  = strap_sync[15:12];
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			strap_meta <= '0;
			strap_sync <= '0;
			strap_vld  <= 2'h0;
			ctl_mode <= STRAP_RESET;
			io_level <= STRAP_RESET;
			up_eq    <= {STRAP_RESET, STRAP_RESET};
			down_eq  <= {STRAP_RESET, STRAP_RESET};
			out_cfg  <= {STRAP_RESET, STRAP_RESET};
			captured <= 1'b0;
		end else begin
			strap_meta <= next_strap_meta;
			strap_sync <= next_strap_sync;
			strap_vld  <= next_strap_vld;
			ctl_mode <= next_ctl_mode;
			io_level <= next_io_level;
			up_eq    <= next_up_eq;
			down_eq  <= next_down_eq;
			out_cfg  <= next_out_cfg;
			captured <= next_captured;
		end
	end

	// ------------------------------------------------------------
	// hot plug low timer
	// ------------------------------------------------------------
	logic [HPD_CNT_W-1:0] hpd_cnt;
	logic [HPD_CNT_W-1:0] next_hpd_cnt;
	logic                 hpd_lost;
	logic                 next_hpd_lost;

	always_comb begin
		next_hpd_cnt  = hpd_cnt;
		next_hpd_lost = hpd_lost;
		if (sync.hot_plug_detect_in) begin
			next_hpd_cnt  = '0;
			next_hpd_lost = 1'b0;
		end else if (hpd_cnt < HPD_CNT_W'(HPD_CYCLES)) begin
			next_hpd_cnt = hpd_cnt + 1'b1;
		end else begin
			next_hpd_lost = 1'b1;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			hpd_cnt  <= '0;
			hpd_lost <= 1'b0;
		end else begin
			hpd_cnt  <= next_hpd_cnt;
			hpd_lost <= next_hpd_lost;
		end
	end

	// ------------------------------------------------------------
	// control decode, all outputs registered
	// ------------------------------------------------------------
	logic        gpio_mode;
	logic        sleep;
	logic [15:0] next_flags;
	logic [3:0]  next_up_o;
	logic [3:0]  next_down_o;

	always_comb begin
		gpio_mode = (ctl_mode == RDCFG_LVL_0) || (ctl_mode == RDCFG_LVL_F);
		sleep     = !sync.sleep_in_n;
		// swap exchanges the two equalizer settings between the paths
		next_up_o   = sync.swap ? down_eq : up_eq;
		next_down_o = sync.swap ? up_eq : down_eq;
		next_flags = '0;
		next_flags[0]  = !gpio_mode;
		next_flags[1]  = (ctl_mode == RDCFG_LVL_R);
		next_flags[2]  = (ctl_mode != RDCFG_LVL_F);
		next_flags[3]  = (ctl_mode == RDCFG_LVL_0) && sync.flip_scl;
		next_flags[4]  = (ctl_mode == RDCFG_LVL_0) && sync.ctl_sda;
		next_flags[5]  = (ctl_mode != RDCFG_LVL_0) && sync.flip_scl;
		next_flags[6]  = (ctl_mode != RDCFG_LVL_0) && sync.ctl_sda;
		next_flags[7]  = gpio_mode ? sync.dp_enable_in : i_reg_dp_enable;
		next_flags[8]  = next_flags[7] && !(gpio_mode && hpd_lost);
		next_flags[9]  = io_level[1];
		next_flags[10] = io_level[0];
		next_flags[11] = !sleep;
		next_flags[12] = !(sleep && i_link_state == RDCFG_LINK_DISC);
		// only the low-power link states lose los and lfps detection
		next_flags[13] = !(sleep && i_link_state == RDCFG_LINK_U2U3);
		next_flags[14] = sync.swap;
		// hpd loss keeps the aux switch closed, only lanes drop
		next_flags[15] = next_flags[7] || (gpio_mode && hpd_lost);
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			{O_SERIAL_EN, O_TEST_MODE, O_AUX_SNOOP_EN, O_FLIP, O_USB_EN} <= '0;
			{O_SCL, O_SDA, O_DP_EN, O_DP_LANES_EN} <= '0;
			O_UP_EQ          <= '0;
			O_DOWN_EQ        <= '0;
			O_OUT_CFG        <= '0;
			O_ADDR_SEL       <= '0;
			O_LANE_DIR       <= '0;
			O_SWAP           <= SWAP_DEFAULT;
			O_CFG_IO_1V8     <= 1'b0;
			O_SERIAL_IO_1V8  <= 1'b0;
			O_RX_DETECT_EN   <= 1'b0;
			O_RX_TERM_EN     <= 1'b0;
			O_LOS_LFPS_EN    <= 1'b0;
			O_SBU_CROSS      <= 1'b0;
			O_AUX_SBU_CLOSED <= 1'b0;
		end else begin
			O_SERIAL_EN      <= next_flags[0];
			O_TEST_MODE      <= next_flags[1];
			O_AUX_SNOOP_EN   <= next_flags[2];
			O_FLIP           <= next_flags[3];
			O_USB_EN         <= next_flags[4];
			O_SCL            <= next_flags[5];
			O_SDA            <= next_flags[6];
			O_DP_EN          <= next_flags[7];
			O_DP_LANES_EN    <= next_flags[8];
			O_UP_EQ          <= next_up_o;
			O_DOWN_EQ        <= next_down_o;
			O_OUT_CFG        <= out_cfg;
			O_ADDR_SEL       <= next_flags[0] ? up_eq : 4'h0;
			O_LANE_DIR       <= sync.lane_dir_sel;
			O_SWAP           <= next_flags[14];
			O_CFG_IO_1V8     <= next_flags[9];
			O_SERIAL_IO_1V8  <= next_flags[10];
			O_RX_DETECT_EN   <= next_flags[11];
			O_RX_TERM_EN     <= next_flags[12];
			O_LOS_LFPS_EN    <= next_flags[13];
			O_SBU_CROSS      <= (ctl_mode == RDCFG_LVL_0) ? sync.flip_scl : 1'b0;
			O_AUX_SBU_CLOSED <= next_flags[15];
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	chk_swap_exchange: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		captured && sync.swap |=> O_UP_EQ == $past(down_eq)) else $error("swap eq wrong");
	chk_sleep_rxdet: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		!sync.sleep_in_n |=> !O_RX_DETECT_EN) else $error("rx detect on in sleep");
	chk_u2u3_term: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		!sync.sleep_in_n && i_link_state == RDCFG_LINK_U2U3
		|=> !O_LOS_LFPS_EN && O_RX_TERM_EN) else $error("u2u3 sleep wrong");
	chk_disc_term: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		!sync.sleep_in_n && i_link_state == RDCFG_LINK_DISC
		|=> !O_RX_TERM_EN && !O_RX_DETECT_EN) else $error("disc sleep wrong");
	chk_serial_mode: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		captured && ctl_mode == RDCFG_LVL_1 |=> O_SERIAL_EN && !O_FLIP && !O_USB_EN)
		else $error("serial mode wrong");
	chk_flip_pin: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		ctl_mode == RDCFG_LVL_0 |=> O_FLIP == $past(sync.flip_scl) && !O_SCL)
		else $error("flip routing wrong");
	chk_dp_source: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		ctl_mode == RDCFG_LVL_1 |=> O_DP_EN == $past(i_reg_dp_enable))
		else $error("dp enable source wrong");
	chk_hpd_drop: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		hpd_lost && gpio_mode |=> !O_DP_LANES_EN && O_AUX_SBU_CLOSED)
		else $error("hpd loss wrong");
	chk_strap_hold: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		captured |=> $stable(ctl_mode) && $stable(up_eq)) else $error("strap changed");
endmodule

// ---- verification/rdcfg_bench.sv ----
// self-checking bench of the strap and pin decode against a behavioural model
// assumes the host model drives every design input on the falling edge
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
	$display("Error at %0t: got %h want %h", $time, (a), (e)); end end
module rdcfg_bench;
	import rdcfg_pkg::*;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	// short hot plug count keeps the loss scenario brief
	localparam int unsigned HPD_SIM = 8;
	logic        clk = 1'b0;
	logic [15:0] rq_strap = 16'h0000;
	logic [7:0]  rq_pin = 8'h22;
	logic [3:0]  rq_misc = 4'h8;
	logic [15:0] cap = 16'h0000;
	logic [15:0] rnd = 16'h7740;
	int          modes[$] = '{3, 1, 2, 0};
	int          err_total = 0;
	int          checks = 0;
	wire  [15:0] strap;
	wire  [7:0]  pin;
	wire  [3:0]  misc;
	wire  [8:0]  ob;
	wire  [7:0]  oc;
	wire  [3:0]  up, dn, cfg, adr;
	wire  [1:0]  dir;

	always #50 clk = ~clk;

	rdcfg_host_model rdcfg_host_model_i (.i_clock(clk), .i_strap(rq_strap), .i_pin(rq_pin),
		.i_misc(rq_misc), .o_strap(strap), .o_pin(pin), .o_misc(misc));

	rdcfg_top #(.HPD_CYCLES(HPD_SIM)) rdcfg_top_i (
		.I_CLOCK(clk), .I_RST(misc[3]), .i_ctl_mode_strap(strap[1:0]),
		.i_io_level_strap(strap[3:2]), .i_up_eq_strap_lo(strap[5:4]),
		.i_up_eq_strap_hi(strap[7:6]), .i_down_eq_strap_lo(strap[9:8]),
		.i_down_eq_strap_hi(strap[11:10]), .i_out_cfg_strap_lo(strap[13:12]),
		.i_out_cfg_strap_hi(strap[15:14]), .i_swap(pin[0]), .i_sleep_in_n(pin[1]),
		.i_flip_scl(pin[2]), .i_usb_switch_enable_in(pin[3]), .i_dp_enable_in(pin[4]),
		.i_hot_plug_detect_in(pin[5]), .i_lane_dir_sel_lo(pin[6]),
		.i_lane_dir_sel_hi(pin[7]), .i_link_state(misc[1:0]), .i_reg_dp_enable(misc[2]),
		.O_SERIAL_EN(ob[8]), .O_TEST_MODE(ob[7]), .O_AUX_SNOOP_EN(ob[6]), .O_FLIP(ob[5]),
		.O_USB_EN(ob[4]), .O_SCL(ob[3]), .O_SDA(ob[2]), .O_DP_EN(ob[1]),
		.O_DP_LANES_EN(ob[0]), .O_UP_EQ(up), .O_DOWN_EQ(dn), .O_OUT_CFG(cfg),
		.O_ADDR_SEL(adr), .O_LANE_DIR(dir), .O_SWAP(oc[7]), .O_CFG_IO_1V8(oc[6]),
		.O_SERIAL_IO_1V8(oc[5]), .O_RX_DETECT_EN(oc[4]), .O_RX_TERM_EN(oc[3]),
		.O_LOS_LFPS_EN(oc[2]), .O_SBU_CROSS(oc[1]), .O_AUX_SBU_CLOSED(oc[0]));

	// ------------------------------------------------------------
	// model and helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] xs(input logic [15:0] v);
		logic [15:0] t;
		t = v ^ (v << 7);
		t = t ^ (t >> 9);
		return t ^ (t << 8);
	endfunction

	// valid only while hot plug is held high
	task automatic check_all();
		logic [1:0] m;
		logic ser, sw, sl, e_dp;
		m = cap[1:0];
		ser = (m == 2'h1) || (m == 2'h3);
		sw = rq_pin[0];
		sl = rq_pin[1];
		e_dp = ser ? rq_misc[2] : rq_pin[4];
		`CHK(ob[8:6], {ser, m == 2'h1, m != 2'h2})
		`CHK(ob[5:4], (m == 2'h0) ? {rq_pin[2], rq_pin[3]} : 2'h0)
		`CHK(ob[3:2], (m != 2'h0) ? {rq_pin[2], rq_pin[3]} : 2'h0)
		`CHK(ob[1], e_dp)
		`CHK({ob[0], oc[0]}, {e_dp, e_dp})
		`CHK(up, sw ? cap[11:8] : cap[7:4])
		`CHK(dn, sw ? cap[7:4] : cap[11:8])
		`CHK(cfg, cap[15:12])
		`CHK(adr, ser ? cap[7:4] : 4'h0)
		`CHK(dir, rq_pin[7:6])
		`CHK(oc[7:5], {sw, cap[3:2]})
		`CHK(oc[4], sl)
		`CHK(oc[3], !(!sl && rq_misc[1:0] == 2'h2))
		`CHK(oc[2], !(!sl && rq_misc[1:0] == 2'h1))
		`CHK(oc[1], (m == 2'h0) ? rq_pin[2] : 1'b0)
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic rand_step();
		rnd = xs(rnd);
		rq_pin = rnd[7:0] | 8'h20;
		rq_misc[1:0] = (rnd[9:8] == 2'h3) ? 2'h0 : rnd[9:8];
		rq_misc[2] = rnd[10];
		settle(5);
		check_all();
	endtask

	task automatic do_reset(input logic [15:0] s);
		rq_misc[3] = 1'b1;
		rq_strap = s;
		cap = s;
		settle(2);
		`CHK({ob, up, dn, cfg, adr, dir, oc}, 35'h0_0000_0000)
		rq_misc[3] = 1'b0;
		settle(6);
		check_all();
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		foreach (modes[k]) begin
			rnd = xs(rnd);
			do_reset({rnd[15:4], 2'(3 - modes[k]), 2'(modes[k])});
			repeat (12) rand_step();
			// straps moved after capture must be ignored until the next reset
			rq_strap = ~cap;
			rand_step();
			`CHK(cfg, cap[15:12])
			$display("decode test for control mode %0d done", modes[k]);
		end
		do_reset(16'h0000);
		rq_pin = 8'h32;
		settle(5);
		`CHK(ob[0], 1'b1)
		rq_pin = 8'h12;
		settle(HPD_SIM - 4);
		rq_pin = 8'h32;
		settle(6);
		`CHK(ob[0], 1'b1)
		rq_pin = 8'h12;
		// two sync edges, HPD_SIM counted edges, one edge to flag and one to the output
		settle(HPD_SIM + 2);
		`CHK(ob[0], 1'b1)
		settle(2);
		`CHK({ob[0], oc[0]}, 2'h1)
		$display("hot plug loss test done");
		tally_and_finish();
	end

	// a stuck run counts as a mismatch; the tests need under 1000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		tally_and_finish();
	end
endmodule

// ---- verification/rdcfg_host_model.sv ----
// partner: host side that drives the straps, the two-level pins and the reset of the decode
// assumes requests change away from the falling edge; every pin moves only on that edge
`timescale 1ns/100ps
module rdcfg_host_model (
	input  wire logic        i_clock,
	input  wire logic [15:0] i_strap,
	input  wire logic [7:0]  i_pin,
	input  wire logic [3:0]  i_misc,
	output logic      [15:0] o_strap,
	output logic      [7:0]  o_pin,
	output logic      [3:0]  o_misc
);
	// ------------------------------------------------------------
	// pin drive
	// ------------------------------------------------------------
	// straps and pins are plain levels; the host keeps them static between updates
	initial begin
		o_strap = i_strap;
		o_pin = i_pin;
		o_misc = i_misc;
		forever begin
			@(negedge i_clock);
			o_strap <= i_strap;
			o_pin <= i_pin;
			o_misc <= i_misc;
		end
	end
endmodule
